//--- hw/pmps_consts.svh
// Constants for the power-mode and pin-state controller.
// Assumes inclusion by bare name from files under hw/.
`ifndef PMPS_CONSTS_SVH
`define PMPS_CONSTS_SVH

`define PMPS_CLK_PERIOD_NS 50
`define PMPS_OSC_START_NS 1000
`define PMPS_AD_WIDTH 13
`define PMPS_PS_DIV_MAX 3'h6
`define PMPS_PS_DIV_RESET 3'h0
`define PMPS_PS_EN_RESET 1'b0
`define PMPS_PRESCALE_W 6
`define PMPS_OSC_CNT_W 12
`define PMPS_STRAP_RESET 1'b1
// Synchroniser reset: device reset on, strap at its pulled-high level, no wake
`define PMPS_SYNC_RESET 3'h3

`endif

//--- hw/pmps_pkg.sv
// Types shared by the power-mode and pin-state controller files.
// Assumes no other package is needed.
package pmps_pkg;

  // Power mode requested by software
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_PDOWN = 2'b10
  } pmps_mode_type;

  // Clock controller state
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_IDLE = 2'b01,
    ST_PDOWN = 2'b10,
    ST_OSC_WAKE = 2'b11
  } pmps_state_type;

  // What a pin does in one non-active condition
  typedef enum logic [2:0] {
    BEH_HIGH = 3'b000,
    BEH_LOW = 3'b001,
    BEH_FLOAT = 3'b010,
    BEH_ACTIVE = 3'b011,
    BEH_RETAIN = 3'b100,
    BEH_WEAK_HIGH = 3'b101
  } pmps_pin_beh_type;

endpackage

//--- hw/pmps_cond_if.sv
// Condition bundle passed from the mode controller to each pin group.
// Assumes all signals are on sys_clk.
`timescale 1ns/1ps
interface pmps_cond_if;
  logic holdAck;
  logic inReset;
  logic idleMode;
  logic powerDown;
  logic boardTest;
  modport ctrl (output holdAck, output inReset, output idleMode, output powerDown,
    output boardTest);
  modport pin (input holdAck, input inReset, input idleMode, input powerDown,
    input boardTest);
endinterface

//--- hw/pmps_pin_group.sv
// Output-state logic for one group of pins with two selectable functions.
// Assumes functional data from logic on sys_clk; outputs feed pad cells.
`timescale 1ns/1ps
module pmps_pin_group
  import pmps_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter pmps_pin_beh_type HOLD_A = BEH_ACTIVE,
  parameter pmps_pin_beh_type RESET_A = BEH_FLOAT,
  parameter pmps_pin_beh_type IDLE_A = BEH_ACTIVE,
  parameter pmps_pin_beh_type PDOWN_A = BEH_RETAIN,
  parameter pmps_pin_beh_type HOLD_B = BEH_ACTIVE,
  parameter pmps_pin_beh_type RESET_B = BEH_FLOAT,
  parameter pmps_pin_beh_type IDLE_B = BEH_ACTIVE,
  parameter pmps_pin_beh_type PDOWN_B = BEH_RETAIN
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  pmps_cond_if.pin cond,
  input wire logic funcSelB,
  input wire logic [WIDTH-1:0] funcOut,
  input wire logic funcDrive,
  output logic [WIDTH-1:0] pinOut,
  output logic pinOeN,
  output logic pinPullUp
);

  if (WIDTH < 1)
  begin : gWidthCheck
    $error("pmps_pin_group: WIDTH must be at least 1");
  end

  pmps_pin_beh_type beh;
  logic [WIDTH-1:0] outD;
  logic oeND;
  logic pullD;

  // Pick the behaviour of the selected function for the current condition
  always_comb
  begin
    beh = BEH_ACTIVE;
    if (cond.inReset)
      beh = funcSelB ? RESET_B : RESET_A;
    else if (cond.powerDown)
      beh = funcSelB ? PDOWN_B : PDOWN_A;
    else if (cond.idleMode)
      beh = funcSelB ? IDLE_B : IDLE_A;
    else if (cond.holdAck)
      beh = funcSelB ? HOLD_B : HOLD_A;
  end

  // Turn the behaviour into pad controls; board test floats all of it
  always_comb
  begin
    outD = pinOut;
    oeND = pinOeN;
    pullD = 1'b0;
    case (beh)
      BEH_HIGH:
      begin
        outD = '1;
        oeND = 1'b0;
      end
      BEH_LOW:
      begin
        outD = '0;
        oeND = 1'b0;
      end
      BEH_FLOAT:
      begin
        oeND = 1'b1;
      end
      BEH_WEAK_HIGH:
      begin
        oeND = 1'b1;
        pullD = 1'b1;
      end
      BEH_RETAIN:
      begin
        outD = pinOut;
        oeND = pinOeN;
      end
      default:
      begin
        outD = funcOut;
        oeND = ~funcDrive;
      end
    endcase
    if (cond.boardTest)
    begin
      oeND = 1'b1;
      pullD = 1'b0;
    end
  end

  // Registered pad controls; retain keeps pinOut and pinOeN, drops the pull
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinOut <= '0;
      pinOeN <= 1'b1;
      pinPullUp <= 1'b0;
    end
    else
    begin
      pinOut <= outD;
      pinOeN <= oeND;
      pinPullUp <= pullD;
    end
  end

endmodule

//--- hw/pmps_power_mode_ctrl.sv
// Power-mode clock control and per-mode pin output states.
// Assumes sys_clk is the external input clock at 20 MHz and that the
// pad ring resolves the level of each pin from its output enable.
// Operation
// - Active mode runs units at half input rate
// - Idle stops execution and bus clocks low
// - Powerdown stops all clocks, oscillator off
// - Powersave divides clocks, down to one sixty-fourth
// - Powersave also works together with idle
// - Test pin low in reset enters board test
// - Board test floats all pins but crystal drive
// - Pin behaviour defined for hold, reset, idle, powerdown
// - Pins drive, float, toggle, retain or pull weakly
// - Multifunction pins follow selected function's behaviour
// - Address/data float in hold, reset; low in idle, powerdown
// - Output clock half rate, toggles on falling edge
`timescale 1ns/1ps
`include "pmps_consts.svh"
module pmps_power_mode_ctrl
  import pmps_pkg::*;
#(
  parameter int AD_WIDTH = `PMPS_AD_WIDTH,
  parameter int OSC_START_NS = `PMPS_OSC_START_NS
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic resetInputPin_n,
  input wire logic addr19PinIn,
  input wire logic wakeRequest,
  input wire logic holdAck,
  input wire logic pwrWrite,
  input wire pmps_mode_type pwrModeIn,
  input wire logic pwrSaveEnIn,
  input wire logic [2:0] pwrSaveDivIn,
  input wire logic [AD_WIDTH-1:0] addrDataOutIn,
  input wire logic addrDataDrive,
  input wire logic addr19OutIn,
  input wire logic addr19Drive,
  input wire logic port3SerialSel,
  input wire logic port3PortOut,
  input wire logic port3SerialClkOut,
  input wire logic port3Drive,
  output logic halfRateOutputClock,
  output logic halfRateOutputClockOeN,
  output logic execUnitClk,
  output logic busUnitClk,
  output logic periphClk,
  output logic crystalDriveEnable,
  output logic resetOutput,
  output logic boardTestFloatMode,
  output pmps_state_type powerState,
  output logic [AD_WIDTH-1:0] addrDataPinOut,
  output logic addrDataPinOeN,
  output logic addr19PinOut,
  output logic addr19PinOeN,
  output logic addr19PinPullUp,
  output logic port3PinOut,
  output logic port3PinOeN
);

  // Oscillator restart wait, rounded up to whole cycles
  localparam int OSC_START_CYC =
    (OSC_START_NS + `PMPS_CLK_PERIOD_NS - 1) / `PMPS_CLK_PERIOD_NS;

  if (AD_WIDTH < 1 || OSC_START_CYC < 1 || OSC_START_CYC >= (1 << `PMPS_OSC_CNT_W))
  begin : gParamCheck
    $error("pmps_power_mode_ctrl: AD_WIDTH or OSC_START_NS out of range");
  end

  // Prescale divide count for a divisor code, clamped to 1/64
  function automatic logic [`PMPS_PRESCALE_W-1:0] divCount(input logic en,
    input logic [2:0] code);
    logic [2:0] c;
    c = (code > `PMPS_PS_DIV_MAX) ? `PMPS_PS_DIV_MAX : code;
    if (!en)
      divCount = '0;
    else
      divCount = `PMPS_PRESCALE_W'((7'h1 << c) - 7'h1);
  endfunction

  pmps_cond_if cond ();

  // Two-stage synchronisers for pin inputs; stage one is read by stage two only
  logic [2:0] syncMeta_q;
  logic [2:0] syncOut_q;
  logic inResetSync;
  logic strapSync;
  logic wakeSync;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncMeta_q <= `PMPS_SYNC_RESET; // Strap idles high, else false board test
      syncOut_q <= `PMPS_SYNC_RESET;
    end
    else
    begin
      syncMeta_q <= {wakeRequest, addr19PinIn, ~resetInputPin_n};
      syncOut_q <= syncMeta_q;
    end
  end

  assign inResetSync = syncOut_q[0];
  assign strapSync = syncOut_q[1];
  assign wakeSync = syncOut_q[2];

  // Device reset state follows the reset pin
  logic inReset_q;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      inReset_q <= 1'b1;
    else
      inReset_q <= inResetSync;
  end

  assign resetOutput = inReset_q;

  // Strap sampled during reset and caught as reset ends
  logic strap_q;
  logic boardTest_q;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_q <= `PMPS_STRAP_RESET;
      boardTest_q <= 1'b0;
    end
    else
    begin
      if (inResetSync)
        strap_q <= strapSync;
      if (inReset_q && !inResetSync)
        boardTest_q <= ~strap_q;
    end
  end

  assign boardTestFloatMode = boardTest_q;

  // Software power setting, held until rewritten or reset
  pmps_mode_type modeReq_q;
  logic modeReqNew_q;
  logic psEn_q;
  logic [2:0] psDiv_q;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      modeReq_q <= MODE_ACTIVE;
      modeReqNew_q <= 1'b0;
      psEn_q <= `PMPS_PS_EN_RESET;
      psDiv_q <= `PMPS_PS_DIV_RESET;
    end
    else if (inReset_q)
    begin
      modeReq_q <= MODE_ACTIVE;
      modeReqNew_q <= 1'b0;
      psEn_q <= `PMPS_PS_EN_RESET;
      psDiv_q <= `PMPS_PS_DIV_RESET;
    end
    else if (pwrWrite)
    begin
      modeReq_q <= pwrModeIn;
      modeReqNew_q <= 1'b1;
      psEn_q <= pwrSaveEnIn;
      psDiv_q <= pwrSaveDivIn;
    end
    else
      modeReqNew_q <= 1'b0;
  end

  // Mode state machine; wake request returns idle or powerdown to active
  pmps_state_type state_q;
  logic [`PMPS_OSC_CNT_W-1:0] oscCnt_q;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= ST_RUN;
    else if (inReset_q)
      state_q <= ST_RUN;
    else
    begin
      case (state_q)
        ST_RUN:
        begin
          if (modeReqNew_q && modeReq_q == MODE_IDLE)
            state_q <= ST_IDLE;
          else if (modeReqNew_q && modeReq_q == MODE_PDOWN)
            state_q <= ST_PDOWN;
        end
        ST_IDLE:
        begin
          if (wakeSync)
            state_q <= ST_RUN;
        end
        ST_PDOWN:
        begin
          if (wakeSync)
            state_q <= ST_OSC_WAKE;
        end
        default:
        begin
          if (oscCnt_q == `PMPS_OSC_CNT_W'(OSC_START_CYC - 1))
            state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Oscillator restart counter, only counts while waking
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      oscCnt_q <= '0;
    else if (state_q == ST_OSC_WAKE)
      oscCnt_q <= oscCnt_q + `PMPS_OSC_CNT_W'(1);
    else
      oscCnt_q <= '0;
  end

  assign powerState = state_q;
  // Crystal stays on in every state except powerdown
  assign crystalDriveEnable = (state_q != ST_PDOWN);

  // Prescaler: a tick every divCount+1 input cycles
  logic [`PMPS_PRESCALE_W-1:0] preCnt_q;
  logic tick;
  logic clocksFrozen;
  logic cpuRun;

  assign tick = (preCnt_q >= divCount(psEn_q, psDiv_q));
  assign clocksFrozen = (state_q == ST_PDOWN) || (state_q == ST_OSC_WAKE);
  // Powersave keeps dividing in idle too: only the gates below change
  assign cpuRun = (state_q == ST_RUN);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      preCnt_q <= '0;
    else if (tick || clocksFrozen)
      preCnt_q <= '0;
    else
      preCnt_q <= preCnt_q + `PMPS_PRESCALE_W'(1);
  end

  // Internal clocks toggle per tick: half the input rate undivided.
  // CPU clocks copy the peripheral phase so they restart in step.
  logic periphClk_q;
  logic execClk_q;
  logic busClk_q;
  logic periphNext;

  assign periphNext = tick ? ~periphClk_q : periphClk_q;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      periphClk_q <= 1'b0;
      execClk_q <= 1'b0;
      busClk_q <= 1'b0;
    end
    else if (clocksFrozen)
    begin
      periphClk_q <= 1'b0;
      execClk_q <= 1'b0;
      busClk_q <= 1'b0;
    end
    else
    begin
      periphClk_q <= periphNext;
      execClk_q <= cpuRun & periphNext;
      busClk_q <= cpuRun & periphNext;
    end
  end

  assign periphClk = periphClk_q;
  assign execUnitClk = execClk_q;
  assign busUnitClk = busClk_q;

  // Output clock on the falling edge; held in powerdown, floated in test
  logic outClk_q;

  always_ff @(negedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      outClk_q <= 1'b0;
    else if (!clocksFrozen)
      outClk_q <= ~outClk_q;
  end

  assign halfRateOutputClock = outClk_q;
  assign halfRateOutputClockOeN = boardTest_q;

  // Conditions shared by all pin groups
  assign cond.holdAck = holdAck;
  assign cond.inReset = inReset_q;
  assign cond.idleMode = (state_q == ST_IDLE);
  assign cond.powerDown = clocksFrozen;
  assign cond.boardTest = boardTest_q;

  // Address/data: float in hold and reset, low in idle and powerdown
  pmps_pin_group #(
    .WIDTH(AD_WIDTH),
    .HOLD_A(BEH_FLOAT),
    .RESET_A(BEH_FLOAT),
    .IDLE_A(BEH_LOW),
    .PDOWN_A(BEH_LOW),
    .HOLD_B(BEH_FLOAT),
    .RESET_B(BEH_FLOAT),
    .IDLE_B(BEH_LOW),
    .PDOWN_B(BEH_LOW)
  ) uAddrData (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cond(cond),
    .funcSelB(1'b0),
    .funcOut(addrDataOutIn),
    .funcDrive(addrDataDrive),
    .pinOut(addrDataPinOut),
    .pinOeN(addrDataPinOeN),
    .pinPullUp()
  );

  // Address 19 / status / test strap: weak pull high during reset
  pmps_pin_group #(
    .WIDTH(1),
    .HOLD_A(BEH_FLOAT),
    .RESET_A(BEH_WEAK_HIGH),
    .IDLE_A(BEH_LOW),
    .PDOWN_A(BEH_LOW),
    .HOLD_B(BEH_FLOAT),
    .RESET_B(BEH_WEAK_HIGH),
    .IDLE_B(BEH_LOW),
    .PDOWN_B(BEH_LOW)
  ) uAddr19 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cond(cond),
    .funcSelB(1'b0),
    .funcOut(addr19OutIn),
    .funcDrive(addr19Drive),
    .pinOut(addr19PinOut),
    .pinOeN(addr19PinOeN),
    .pinPullUp(addr19PinPullUp)
  );

  // Port bit retains in hold; serial clock function keeps running in hold and idle, retains in powerdown
  logic port3Func;

  assign port3Func = port3SerialSel ? port3SerialClkOut : port3PortOut;

  pmps_pin_group #(
    .WIDTH(1),
    .HOLD_A(BEH_RETAIN),
    .RESET_A(BEH_FLOAT),
    .IDLE_A(BEH_RETAIN),
    .PDOWN_A(BEH_RETAIN),
    .HOLD_B(BEH_ACTIVE),
    .RESET_B(BEH_FLOAT),
    .IDLE_B(BEH_ACTIVE),
    .PDOWN_B(BEH_RETAIN)
  ) uPort3Bit0 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cond(cond),
    .funcSelB(port3SerialSel),
    .funcOut(port3Func),
    .funcDrive(port3Drive),
    .pinOut(port3PinOut),
    .pinOeN(port3PinOeN),
    .pinPullUp()
  );

endmodule

//--- sim/pmps_power_mode_ctrl_props.sv
// Concurrent checks on the power-mode controller's top-level ports.
// Assumes sys_clk and async active-low reset_n; bound by the bind below.
`timescale 1ns/1ps
module pmps_power_mode_ctrl_props
  import pmps_pkg::*;
#(
  parameter int AD_WIDTH = 13
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic resetInputPin_n,
  input wire logic wakeRequest,
  input wire logic holdAck,
  input wire logic pwrWrite,
  input wire pmps_mode_type pwrModeIn,
  input wire logic halfRateOutputClock,
  input wire logic halfRateOutputClockOeN,
  input wire logic execUnitClk,
  input wire logic busUnitClk,
  input wire logic periphClk,
  input wire logic crystalDriveEnable,
  input wire logic resetOutput,
  input wire logic boardTestFloatMode,
  input wire pmps_state_type powerState,
  input wire logic [AD_WIDTH-1:0] addrDataPinOut,
  input wire logic addrDataPinOeN,
  input wire logic addr19PinOeN,
  input wire logic addr19PinPullUp,
  input wire logic port3PinOeN
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Idle request accepted only from run with no wake pending
  sequence s_idleWrite;
    pwrWrite && pwrModeIn == MODE_IDLE && !resetOutput && powerState == ST_RUN && !wakeRequest;
  endsequence
  sequence s_idleEntered;
    ##2 powerState == ST_IDLE;
  endsequence
  property p_idleEntry;
    s_idleWrite |-> s_idleEntered;
  endproperty
  a_idleEntry: assert property (p_idleEntry) else $error("idle not entered");

  property p_idleFreeze;
    (powerState == ST_IDLE) [*2] |-> !execUnitClk && !busUnitClk;
  endproperty
  a_idleFreeze: assert property (p_idleFreeze) else $error("cpu clock runs in idle");

  property p_pdownFreeze;
    (powerState == ST_PDOWN) [*2] |-> !execUnitClk && !busUnitClk && !periphClk;
  endproperty
  a_pdownFreeze: assert property (p_pdownFreeze) else $error("clock runs in pdown");

  property p_oscOff;
    crystalDriveEnable == (powerState != ST_PDOWN);
  endproperty
  a_oscOff: assert property (p_oscOff) else $error("oscillator enable wrong");

  // Output clock sampled on the edge that moves it
  property p_outClkToggle;
    @(negedge sys_clk) disable iff (!reset_n)
      (powerState == ST_RUN && !resetOutput) [*3] |->
      halfRateOutputClock != $past(halfRateOutputClock);
  endproperty
  a_outClkToggle: assert property (p_outClkToggle) else $error("output clock stalled");

  property p_holdFloat;
    holdAck && !resetOutput && powerState == ST_RUN |=> addrDataPinOeN;
  endproperty
  a_holdFloat: assert property (p_holdFloat) else $error("ad driven in hold");

  property p_idleLow;
    powerState == ST_IDLE && !resetOutput && !boardTestFloatMode |=>
      !addrDataPinOeN && addrDataPinOut == '0;
  endproperty
  a_idleLow: assert property (p_idleLow) else $error("ad not low in idle");

  property p_testFloat;
    boardTestFloatMode |-> halfRateOutputClockOeN ##1 addrDataPinOeN && addr19PinOeN && port3PinOeN;
  endproperty
  a_testFloat: assert property (p_testFloat) else $error("pin driven in test mode");

  property p_strapPull;
    resetOutput && !boardTestFloatMode |=> addr19PinOeN && addr19PinPullUp && addrDataPinOeN;
  endproperty
  a_strapPull: assert property (p_strapPull) else $error("no weak pull in reset");

  // Two sync stages plus one register before reset shows
  property p_resetSync;
    !resetInputPin_n [*4] |-> resetOutput;
  endproperty
  a_resetSync: assert property (p_resetSync) else $error("reset input not seen");
endmodule

bind pmps_power_mode_ctrl pmps_power_mode_ctrl_props #(.AD_WIDTH(AD_WIDTH)) props (.sys_clk,
  .reset_n, .resetInputPin_n, .wakeRequest, .holdAck, .pwrWrite, .pwrModeIn,
  .halfRateOutputClock, .halfRateOutputClockOeN, .execUnitClk, .busUnitClk, .periphClk,
  .crystalDriveEnable, .resetOutput, .boardTestFloatMode, .powerState, .addrDataPinOut,
  .addrDataPinOeN, .addr19PinOeN, .addr19PinPullUp, .port3PinOeN);

//--- sim/tb_pmps_power_mode_ctrl.sv
// Self-checking bench for the power-mode and pin-state controller.
// Assumes a 50 ns sys_clk; pads are observed through their enables.
`timescale 1ns/1ps
module tb_pmps_power_mode_ctrl
  import pmps_pkg::*;
;
  typedef struct {
    pmps_mode_type mode;
    logic hold, sel;
    pmps_state_type st;
    logic adOeN, a19OeN, p3Out;
  } pmps_row_type;
  logic sys_clk = 0, reset_n = 0, resetInputPin_n = 1, addr19PinIn = 1, wakeRequest = 0;
  logic holdAck = 0, pwrWrite = 0, pwrSaveEnIn = 0, addrDataDrive = 1, addr19OutIn = 1;
  logic addr19Drive = 1, port3SerialSel = 0, port3PortOut = 1, port3SerialClkOut = 1;
  logic port3Drive = 1, halfRateOutputClock, halfRateOutputClockOeN, execUnitClk, busUnitClk;
  logic periphClk, crystalDriveEnable, resetOutput, boardTestFloatMode, addrDataPinOeN;
  logic addr19PinOut, addr19PinOeN, addr19PinPullUp, port3PinOut, port3PinOeN;
  logic [2:0] pwrSaveDivIn = 3'h0;
  logic [12:0] addrDataOutIn = 13'h1fff, addrDataPinOut;
  pmps_mode_type pwrModeIn = MODE_ACTIVE;
  pmps_state_type powerState;
  int n_errors = 0, n_checks = 0, i, c, e, ce;
  pmps_row_type rows[6] = '{'{MODE_ACTIVE, 1, 0, ST_RUN, 1, 1, 1},
    '{MODE_ACTIVE, 1, 1, ST_RUN, 1, 1, 0}, '{MODE_IDLE, 0, 0, ST_IDLE, 0, 0, 1},
    '{MODE_IDLE, 0, 1, ST_IDLE, 0, 0, 0}, '{MODE_PDOWN, 0, 0, ST_PDOWN, 0, 0, 1},
    '{MODE_PDOWN, 0, 1, ST_PDOWN, 0, 0, 1}};

  // Short oscillator wait keeps wake-ups quick
  pmps_power_mode_ctrl #(.OSC_START_NS(100)) dut (.*);

  initial forever #25 sys_clk = ~sys_clk;

  task report_and_stop();
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      #2;
    end
  endtask
  task bail(input logic ok);
    if (!ok)
    begin
      n_errors++;
      $display("[FAIL] %0t wait timed out", $time);
      report_and_stop();
    end
  endtask
  task setPwr(input pmps_mode_type m, input logic en, input logic [2:0] dv);
    pwrModeIn = m;
    pwrSaveEnIn = en;
    pwrSaveDivIn = dv;
    pwrWrite = 1;
    step(1);
    pwrWrite = 0;
  endtask
  // Wake is asynchronous, so allow for sync plus oscillator wait
  task toRun();
    if (powerState !== ST_RUN)
    begin
      wakeRequest = 1;
      for (i = 0; i < 80 && powerState !== ST_RUN; i++) step(1);
      wakeRequest = 0;
    end
    bail(powerState === ST_RUN);
  endtask
  // Strap is only caught while the reset pin is low after system reset ends
  task doReset(input logic strap);
    addr19PinIn = strap;
    resetInputPin_n = 0;
    reset_n = 0;
    step(3);
    reset_n = 1;
    step(2);
    resetInputPin_n = 1;
    for (i = 0; i < 20 && resetOutput !== 1'b0; i++) step(1);
    bail(resetOutput === 1'b0);
    addr19PinIn = 1;
  endtask
  // Counts level changes of peripheral and execution-unit clocks over 128 cycles
  task countClk(output int cp, output int cx);
    logic pp, px;
    cp = 0;
    cx = 0;
    pp = periphClk;
    px = execUnitClk;
    repeat (128)
    begin
      step(1);
      cp += (periphClk !== pp);
      cx += (execUnitClk !== px);
      pp = periphClk;
      px = execUnitClk;
    end
  endtask

  initial
  begin
    doReset(1);
    chk(boardTestFloatMode, 0);
    // Pad states per condition and per selected function
    foreach (rows[r])
    begin
      toRun();
      setPwr(MODE_ACTIVE, 0, 3'h0);
      port3SerialSel = rows[r].sel;
      port3PortOut = 1;
      port3SerialClkOut = 1;
      step(3);
      holdAck = rows[r].hold;
      if (rows[r].mode != MODE_ACTIVE) setPwr(rows[r].mode, 0, 3'h0);
      step(6);
      port3PortOut = 0;
      port3SerialClkOut = 0;
      step(3);
      chk(powerState, rows[r].st);
      chk(addrDataPinOeN, rows[r].adOeN);
      if (!rows[r].adOeN) chk(16'(addrDataPinOut), 16'h0000);
      chk(addr19PinOeN, rows[r].a19OeN);
      if (!rows[r].a19OeN) chk(addr19PinOut, 0);
      chk(port3PinOut, rows[r].p3Out);
      chk(crystalDriveEnable, rows[r].st != ST_PDOWN);
      holdAck = 0;
    end
    // Clock rate unscaled and for every prescale code, clamp included
    toRun();
    for (int k = -1; k < 8; k++)
    begin
      setPwr(MODE_ACTIVE, k >= 0, k < 0 ? 3'h0 : 3'(k));
      step(4);
      countClk(c, ce);
      e = 128 >> (k < 0 ? 0 : (k > 6 ? 6 : k));
      chk(c >= e - 1 && c <= e + 1, 1);
      chk(ce >= e - 1 && ce <= e + 1, 1);
    end
    // Powersave together with idle: peripherals divided, cpu frozen
    setPwr(MODE_IDLE, 1, 3'h2);
    step(4);
    countClk(c, ce);
    chk(c >= 31 && c <= 33, 1);
    chk(ce, 0);
    toRun();
    // Reset pin mid-run, with a write made while reset shows
    resetInputPin_n = 0;
    step(5);
    chk(resetOutput, 1);
    chk({addrDataPinOeN, addr19PinOeN, addr19PinPullUp}, 3'h7);
    setPwr(MODE_IDLE, 0, 3'h0);
    resetInputPin_n = 1;
    for (i = 0; i < 10 && resetOutput !== 1'b0; i++) step(1);
    step(4);
    chk(powerState, ST_RUN);
    // Strap low during reset selects board-test float mode
    doReset(0);
    chk(boardTestFloatMode, 1);
    step(2);
    chk({addrDataPinOeN, addr19PinOeN, port3PinOeN, halfRateOutputClockOeN}, 4'hf);
    chk(crystalDriveEnable, 1);
    doReset(1);
    chk(boardTestFloatMode, 0);
    report_and_stop();
  end
endmodule
